// >>> rtl/srsc_fwd_if.sv
// Carrier between the winding-sense edge detector and the request controller.
`timescale 1ns/1ps
interface srsc_fwd_if;
  logic fallSeen;
  logic blanking;

  modport sense
  (
    output fallSeen,
    output blanking
  );
  modport ctrl
  (
    input  fallSeen,
    input  blanking
  );
endinterface

// >>> rtl/srsc_fwd_sense.sv
// Falling-edge detector on the winding-sense comparator with ringing blanking.
`timescale 1ns/1ps
module srsc_fwd_sense
  import srsc_pkg::*;
#(
  parameter int BLANK_CYCLES = BLANK_CYC
)
(
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic windingHigh,
  srsc_fwd_if.sense fwd
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic        prevHigh_r;
  logic        prevHigh_nxt;
  logic        fall_r;
  logic        fall_nxt;
  logic [11:0] blank_r;
  logic [11:0] blank_nxt;

  if (BLANK_CYCLES < 1 || BLANK_CYCLES > 4095)
  begin : g_chk
    $error("BLANK_CYCLES out of range");
  end

  // A fall starts the blanking interval; falls seen inside it are ringing.
  always_comb
  begin
    prevHigh_nxt = windingHigh;
    fall_nxt     = 1'b0;
    blank_nxt    = blank_r;
    if (blank_r != 12'h000)
    begin
      blank_nxt = blank_r - 12'h001;
    end
    else if (prevHigh_r && !windingHigh)
    begin
      fall_nxt  = 1'b1;
      blank_nxt = 12'(BLANK_CYCLES);
    end
  end

  // Registers of the detector.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      prevHigh_r <= 1'b0;
      fall_r     <= 1'b0;
      blank_r    <= 12'h000;
    end
    else
    begin
      prevHigh_r <= prevHigh_nxt;
      fall_r     <= fall_nxt;
      blank_r    <= blank_nxt;
    end
  end

  assign fwd.fallSeen = fall_r;
  assign fwd.blanking = (blank_r != 12'h000);

  chk_blank_quiet: assert property (@(posedge mclk) disable iff (!resetn)
    fall_r |=> !fall_r [*2]) else $error("fall reported inside blanking");

endmodule

// >>> rtl/srsc_pkg.sv
// Shared timing constants and states of the secondary request and rectifier control.
package srsc_pkg;

  // ****************************************************************
  // Clock and time figures
  // ****************************************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int ON_TIMEOUT_NS = 30000;
  localparam int HS_SPACING_NS = 30000;
  localparam int VALLEY_ON_NS  = 20000;
  localparam int BLANK_NS      = 1000;
  localparam int OFF_MIN_NS    = 2500;
  localparam int CHECK_NS      = 500;

  // Least time in cycles, rounded up and never below one cycle.
  function automatic int cycUp(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // Longest time in cycles, rounded down and never below one cycle.
  function automatic int cycDown(input int ns);
    int c;
    c = (ns * 1000) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int ON_TIMEOUT_CYC = cycDown(ON_TIMEOUT_NS);
  localparam int HS_SPACING_CYC = cycUp(HS_SPACING_NS);
  localparam int VALLEY_ON_CYC  = cycDown(VALLEY_ON_NS);
  localparam int BLANK_CYC      = cycUp(BLANK_NS);
  localparam int OFF_MIN_CYC    = cycUp(OFF_MIN_NS);
  localparam int CHECK_CYC      = cycUp(CHECK_NS);

  // ****************************************************************
  // Control states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_CHECK,
    ST_FAULT,
    ST_HS1,
    ST_HSGAP,
    ST_IDLE,
    ST_ON
  } srsc_state_type;

endpackage

// >>> rtl/srsc_request_ctrl.sv
// Secondary request forwarding and rectifier gate control of a flyback switcher.
// ****************************************************************
// ****************************************************************
`timescale 1ns/1ps
module srsc_request_ctrl
  import srsc_pkg::*;
#(
  parameter int ON_TIMEOUT_CYCLES = ON_TIMEOUT_CYC,
  parameter int HS_SPACING_CYCLES = HS_SPACING_CYC,
  parameter int VALLEY_CYCLES     = VALLEY_ON_CYC,
  parameter int OFF_MIN_CYCLES    = OFF_MIN_CYC
)
(
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic cycleReq,
  input  wire logic windingHigh,
  input  wire logic turnoffBelow,
  input  wire logic dcmDetect,
  input  wire logic valleyPeak,
  input  wire logic capAboveRef,
  input  wire logic gateGrounded,
  output logic      linkPulse_r,
  output logic      reqAck_r,
  output logic      gateDrive_r,
  output logic      gatePullDown_r,
  output logic      gateOpenFault_r,
  output logic      edgeTimingOut_r
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  if (ON_TIMEOUT_CYCLES < 1 || ON_TIMEOUT_CYCLES > 8191 ||
      HS_SPACING_CYCLES < 1 || HS_SPACING_CYCLES > 8191 ||
      VALLEY_CYCLES < 1 || VALLEY_CYCLES > 8191 ||
      OFF_MIN_CYCLES < 1 || OFF_MIN_CYCLES > 8191)
  begin : g_chk
    $error("timing parameter out of range");
  end

  localparam logic [12:0] TMO_LAST = 13'(ON_TIMEOUT_CYCLES - 1);
  localparam logic [12:0] HS_LAST  = 13'(HS_SPACING_CYCLES - 1);
  localparam logic [12:0] CHK_LAST = 13'(CHECK_CYC - 1);

  // ****************************************************************
  // Edge detector
  // ****************************************************************
  srsc_fwd_if fwd ();

  srsc_fwd_sense i_srsc_fwd_sense
  (
    .mclk        (mclk),
    .resetn      (resetn),
    .windingHigh (windingHigh),
    .fwd         (fwd)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  srsc_state_type state_r;
  srsc_state_type state_nxt;
  logic [12:0]    tmr_r;
  logic [12:0]    tmr_nxt;
  logic [12:0]    offCnt_r;
  logic [12:0]    offCnt_nxt;
  logic [12:0]    valleyCnt_r;
  logic [12:0]    valleyCnt_nxt;
  logic           reqPrev_r;
  logic           reqPrev_nxt;
  logic           pend_r;
  logic           pend_nxt;
  logic           inCtrl_r;
  logic           inCtrl_nxt;
  logic           linkPulse_nxt;
  logic           reqAck_nxt;
  logic           gateDrive_nxt;
  logic           gateOpenFault_nxt;
  logic           valleyActive;
  logic           sendOk;
  logic           reqRise;

  // Valley gating window and the combined send permission.
  always_comb
  begin
    valleyActive = dcmDetect && (valleyCnt_r != 13'(VALLEY_CYCLES));
    sendOk       = (offCnt_r == 13'h0000)
                   && (!valleyActive || valleyPeak);
    reqRise      = cycleReq && !reqPrev_r;
  end

  // Next values of the controller.
  always_comb
  begin
    state_nxt         = state_r;
    tmr_nxt           = tmr_r;
    offCnt_nxt        = (offCnt_r != 13'h0000) ? offCnt_r - 13'h0001 : offCnt_r;
    valleyCnt_nxt     = valleyCnt_r;
    reqPrev_nxt       = cycleReq;
    pend_nxt          = pend_r;
    inCtrl_nxt        = inCtrl_r;
    linkPulse_nxt     = 1'b0;
    reqAck_nxt        = 1'b0;
    gateDrive_nxt     = gateDrive_r;
    gateOpenFault_nxt = gateOpenFault_r;

    // Valley window timer runs only while discontinuous mode holds.
    if (!dcmDetect)
    begin
      valleyCnt_nxt = 13'h0000;
    end
    else if (valleyCnt_r != 13'(VALLEY_CYCLES))
    begin
      valleyCnt_nxt = valleyCnt_r + 13'h0001;
    end

    // Discontinuous turn-off on the threshold comparator.
    if (gateDrive_r && dcmDetect && turnoffBelow)
    begin
      gateDrive_nxt = 1'b0;
    end

    case (state_r)
      ST_CHECK:
      begin
        tmr_nxt = tmr_r + 13'h0001;
        if (tmr_r == CHK_LAST)
        begin
          tmr_nxt = 13'h0000;
          if (capAboveRef || gateGrounded)
          begin
            gateOpenFault_nxt = 1'b1;
            state_nxt         = ST_FAULT;
          end
          else
          begin
            state_nxt = ST_HS1;
          end
        end
      end
      ST_FAULT:
      begin
        state_nxt = ST_FAULT;
      end
      ST_HS1:
      begin
        linkPulse_nxt = 1'b1;
        tmr_nxt       = 13'h0000;
        state_nxt     = ST_HSGAP;
      end
      ST_HSGAP:
      begin
        tmr_nxt = tmr_r + 13'h0001;
        if (tmr_r == HS_LAST)
        begin
          linkPulse_nxt = 1'b1;
          inCtrl_nxt    = 1'b1;
          tmr_nxt       = 13'h0000;
          state_nxt     = ST_ON;
        end
      end
      ST_IDLE:
      begin
        if (fwd.fallSeen)
        begin
          inCtrl_nxt    = 1'b0;
          gateDrive_nxt = 1'b0;
          state_nxt     = ST_HS1;
        end
        else if ((pend_r || reqRise) && sendOk)
        begin
          linkPulse_nxt = 1'b1;
          reqAck_nxt    = 1'b1;
          gateDrive_nxt = 1'b0;
          pend_nxt      = 1'b0;
          tmr_nxt       = 13'h0000;
          state_nxt     = ST_ON;
        end
      end
      ST_ON:
      begin
        tmr_nxt = tmr_r + 13'h0001;
        if (fwd.fallSeen)
        begin
          gateDrive_nxt = inCtrl_r;
          offCnt_nxt    = 13'(OFF_MIN_CYCLES);
          state_nxt     = ST_IDLE;
        end
        else if (tmr_r == TMO_LAST)
        begin
          inCtrl_nxt = 1'b0;
          state_nxt  = ST_HS1;
        end
      end
      default:
      begin
        state_nxt = ST_CHECK;
      end
    endcase

    // A new request is held while blocked; a fresh edge wins over the clear.
    if (reqRise && !(state_r == ST_IDLE && linkPulse_nxt && !pend_r))
    begin
      pend_nxt = 1'b1;
    end
    if (!inCtrl_nxt)
    begin
      gateDrive_nxt = 1'b0;
    end
  end

  // Registers of the controller.
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r         <= ST_CHECK;
      tmr_r           <= 13'h0000;
      offCnt_r        <= 13'h0000;
      valleyCnt_r     <= 13'h0000;
      reqPrev_r       <= 1'b0;
      pend_r          <= 1'b0;
      inCtrl_r        <= 1'b0;
      linkPulse_r     <= 1'b0;
      reqAck_r        <= 1'b0;
      gateDrive_r     <= 1'b0;
      gatePullDown_r  <= 1'b1;
      gateOpenFault_r <= 1'b0;
      edgeTimingOut_r <= 1'b0;
    end
    else
    begin
      state_r         <= state_nxt;
      tmr_r           <= tmr_nxt;
      offCnt_r        <= offCnt_nxt;
      valleyCnt_r     <= valleyCnt_nxt;
      reqPrev_r       <= reqPrev_nxt;
      pend_r          <= pend_nxt;
      inCtrl_r        <= inCtrl_nxt;
      linkPulse_r     <= linkPulse_nxt;
      reqAck_r        <= reqAck_nxt;
      gateDrive_r     <= gateDrive_nxt;
      gatePullDown_r  <= !inCtrl_nxt;
      gateOpenFault_r <= gateOpenFault_nxt;
      edgeTimingOut_r <= fwd.fallSeen;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_ack_with_pulse: assert property (@(posedge mclk) disable iff (!resetn)
    reqAck_r |-> linkPulse_r) else $error("acknowledge without link pulse");

  chk_fault_no_pulse: assert property (@(posedge mclk) disable iff (!resetn)
    gateOpenFault_r |=> !linkPulse_r [*8]) else $error("request sent after gate fault");

  chk_pulldown_ctrl: assert property (@(posedge mclk) disable iff (!resetn)
    gateDrive_r |-> !gatePullDown_r) else $error("gate driven while pull-down on");

  chk_pulse_gate_off: assert property (@(posedge mclk) disable iff (!resetn)
    reqAck_r |-> !gateDrive_r) else $error("gate still on at request pulse");

  chk_dcm_turnoff: assert property (@(posedge mclk) disable iff (!resetn)
    (gateDrive_r && dcmDetect && turnoffBelow) |=> !gateDrive_r)
    else $error("gate not off at threshold");

  chk_gate_on_fall: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(gateDrive_r) |-> $past(fwd.fallSeen) && $past(state_r == ST_ON))
    else $error("gate on without requested fall");

  chk_offtime_gap: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(reqAck_r) |-> $past(offCnt_r) == 13'h0000)
    else $error("request inside minimum off-time");

  chk_on_timeout: assert property (@(posedge mclk) disable iff (!resetn)
    (state_r == ST_ON && tmr_r == TMO_LAST && !fwd.fallSeen) |=> ##1 linkPulse_r)
    else $error("on-phase timeout did not restart handshake");

  chk_valley_gate: assert property (@(posedge mclk) disable iff (!resetn)
    (state_r == ST_IDLE && valleyActive && !valleyPeak) |=> !reqAck_r)
    else $error("request outside valley window");

  chk_blank_no_fall: assert property (@(posedge mclk) disable iff (!resetn)
    fwd.blanking |=> !fwd.fallSeen) else $error("fall reported inside blanking window");

endmodule

// >>> tb/secondary_request_sr_control_tb_top.sv
// Self-checking bench of the secondary request and rectifier control.
`timescale 1ns/1ps
module secondary_request_sr_control_tb_top;
  localparam int ON_TO = 60;
  localparam int HS    = 250;
  localparam int VLY   = 50;
  localparam int OFFM  = 10;

  logic mclk;
  logic resetn;
  logic cycleReq;
  logic turnoffBelow;
  logic dcmDetect;
  logic valleyPeak;
  logic capAboveRef;
  logic gateGrounded;
  logic respond;
  logic extraSw;
  logic windingHigh;
  logic linkPulse_r;
  logic reqAck_r;
  logic gateDrive_r;
  logic gatePullDown_r;
  logic gateOpenFault_r;
  logic edgeTimingOut_r;
  int   errorCnt;
  int   cmpCount;
  int   n;

  // ****************************************************************
  // Design and primary model
  // ****************************************************************
  srsc_request_ctrl #(.ON_TIMEOUT_CYCLES(ON_TO), .HS_SPACING_CYCLES(HS),
                      .VALLEY_CYCLES(VLY), .OFF_MIN_CYCLES(OFFM)) i_srsc_request_ctrl
  (
    .mclk(mclk), .resetn(resetn), .cycleReq(cycleReq), .windingHigh(windingHigh),
    .turnoffBelow(turnoffBelow), .dcmDetect(dcmDetect), .valleyPeak(valleyPeak),
    .capAboveRef(capAboveRef), .gateGrounded(gateGrounded),
    .linkPulse_r(linkPulse_r), .reqAck_r(reqAck_r), .gateDrive_r(gateDrive_r),
    .gatePullDown_r(gatePullDown_r), .gateOpenFault_r(gateOpenFault_r),
    .edgeTimingOut_r(edgeTimingOut_r)
  );

  srsc_primary_model #(.GAP_MIN(HS - 10), .GAP_MAX(HS + 10)) i_srsc_primary_model
  (
    .mclk(mclk), .resetn(resetn), .linkPulse_r(linkPulse_r),
    .respond(respond), .extraSw(extraSw), .windingHigh(windingHigh)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic seen, input logic exp, input string msg);
    cmpCount++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("[ERR] %0t ns %s", $time, msg);
    end
  endtask

  // Waits for the link pulse (sel 0) or the edge timing pulse (sel 1).
  task automatic waitEvt(input bit sel, input int maxCyc, output int cnt);
    cnt = 0;
    do
    begin
      @(negedge mclk);
      cnt++;
    end
    while (((sel ? edgeTimingOut_r : linkPulse_r) !== 1'b1) && (cnt < maxCyc));
    check(sel ? edgeTimingOut_r : linkPulse_r, 1'b1, "expected pulse missing");
  endtask

  // Raises a request on a falling edge and waits for its link pulse.
  task automatic reqPulse(input int maxCyc, output int cnt);
    @(negedge mclk);
    cycleReq = 1'b1;
    waitEvt(0, maxCyc, cnt);
    cycleReq = 1'b0;
  endtask

  task automatic stopTest();
    $display("Comparisons %0d, mismatches %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic testStartup();
    check(gatePullDown_r, 1'b1, "pull-down off in reset");
    resetn = 1'b1;
    waitEvt(0, 150, n);
    check(reqAck_r, 1'b0, "ack on handshake pulse");
    waitEvt(0, HS + 5, n);
    check(n == HS, 1'b1, "handshake spacing wrong");
    waitEvt(1, 10, n);
    check(gateDrive_r, 1'b1, "gate off after fall");
    check(gatePullDown_r, 1'b0, "pull-down on in control");
    check(gateOpenFault_r, 1'b0, "false open gate");
    $display("Test startup done");
  endtask

  task automatic testRequest();
    repeat (250) @(negedge mclk);
    check(gateDrive_r, 1'b1, "gate dropped before request");
    reqPulse(4, n);
    check(n <= 2, 1'b1, "request late");
    check(reqAck_r, 1'b1, "no ack with pulse");
    check(gateDrive_r, 1'b0, "gate overlaps request");
    waitEvt(1, 10, n);
    check(gateDrive_r, 1'b1, "gate off after fall");
    $display("Test request done");
  endtask

  task automatic testValley();
    repeat (250) @(negedge mclk);
    dcmDetect = 1'b1;
    @(negedge mclk);
    cycleReq = 1'b1;
    repeat (20)
    begin
      @(negedge mclk);
      check(linkPulse_r, 1'b0, "request outside valley");
    end
    valleyPeak = 1'b1;
    waitEvt(0, 3, n);
    check(reqAck_r, 1'b1, "pending request lost");
    cycleReq = 1'b0;
    valleyPeak = 1'b0;
    waitEvt(1, 10, n);
    turnoffBelow = 1'b1;
    @(negedge mclk);
    check(gateDrive_r, 1'b0, "gate on below threshold");
    turnoffBelow = 1'b0;
    repeat (250) @(negedge mclk);
    reqPulse(4, n);
    check(n <= 2, 1'b1, "valley gating too long");
    dcmDetect = 1'b0;
    waitEvt(1, 10, n);
    $display("Test valley done");
  endtask

  // A primary cycle that was never requested must drop control and restart the handshake.
  task automatic testUnrequested();
    repeat (250) @(negedge mclk);
    check(gateDrive_r, 1'b1, "gate off before stray switching");
    extraSw = 1'b1;
    @(negedge mclk);
    extraSw = 1'b0;
    waitEvt(0, 10, n);
    check(reqAck_r, 1'b0, "ack on handshake after stray switching");
    check(gatePullDown_r, 1'b1, "pull-down off after stray switching");
    check(gateDrive_r, 1'b0, "gate on after stray switching");
    waitEvt(0, HS + 5, n);
    check(n == HS, 1'b1, "handshake spacing wrong");
    waitEvt(1, 10, n);
    check(gateDrive_r, 1'b1, "gate off after handshake fall");
    $display("Test stray switching done");
  endtask

  task automatic testTimeout();
    respond = 1'b0;
    reqPulse(OFFM + 6, n);
    check(n >= OFFM - 1 && n <= OFFM + 3, 1'b1, "off-time broken");
    @(negedge mclk);
    cycleReq = 1'b1;
    waitEvt(0, ON_TO + 10, n);
    check(n >= ON_TO && n <= ON_TO + 4, 1'b1, "inhibit timeout wrong");
    check(reqAck_r, 1'b0, "ack on handshake");
    check(gatePullDown_r, 1'b1, "pull-down off after timeout");
    check(gateDrive_r, 1'b0, "gate on after timeout");
    cycleReq = 1'b0;
    waitEvt(0, HS + 5, n);
    check(n == HS, 1'b1, "handshake spacing wrong");
    $display("Test timeout done");
  endtask

  task automatic testFault(input logic cap, input logic gnd);
    resetn = 1'b0;
    capAboveRef = cap;
    gateGrounded = gnd;
    repeat (4) @(negedge mclk);
    resetn = 1'b1;
    repeat (150) @(negedge mclk);
    check(gateOpenFault_r, 1'b1, "gate fault missed");
    cycleReq = 1'b1;
    n = 0;
    repeat (300)
    begin
      @(negedge mclk);
      if (linkPulse_r !== 1'b0)
        n++;
    end
    check(n == 0, 1'b1, "pulse with faulty gate");
    check(gatePullDown_r, 1'b1, "pull-down off in fault");
    cycleReq = 1'b0;
    $display("Test fault done");
  endtask

  // ****************************************************************
  // Clock, sequence and watchdog
  // ****************************************************************
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial
  begin
    errorCnt = 0;
    cmpCount = 0;
    resetn = 1'b0;
    cycleReq = 1'b0;
    turnoffBelow = 1'b0;
    dcmDetect = 1'b0;
    valleyPeak = 1'b0;
    capAboveRef = 1'b0;
    gateGrounded = 1'b0;
    respond = 1'b1;
    extraSw = 1'b0;
    repeat (4) @(negedge mclk);
    testStartup();
    testRequest();
    testValley();
    testUnrequested();
    testTimeout();
    testFault(1'b1, 1'b0);
    testFault(1'b0, 1'b1);
    stopTest();
  end

  // Cuts a hang short well after the expected run time.
  initial
  begin
    #100000;
    errorCnt++;
    $display("[ERR] %0t ns watchdog expired", $time);
    stopTest();
  end
endmodule

// >>> tb/srsc_primary_model.sv
// Behavioural primary controller that answers link pulses with winding-sense falls.
`timescale 1ns/1ps
module srsc_primary_model
#(
  parameter int RESP_CYC = 3,
  parameter int LOW_CYC  = 5,
  parameter int GAP_MIN  = 30,
  parameter int GAP_MAX  = 60
)
(
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic linkPulse_r,
  input  wire logic respond,
  input  wire logic extraSw,
  output logic      windingHigh
);
  // ****************************************************************
  // Handover and on-phase response
  // ****************************************************************
  int   gap;
  int   dly;
  int   low;
  logic slave;
  logic pair;

  // Two pulses near the handshake spacing hand switching to the secondary.
  assign pair = (gap >= GAP_MIN) && (gap <= GAP_MAX);

  // Each pulse taken in slave mode, or closing a pair, starts one on-phase while respond is set, seen as a short fall.
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      gap         <= 0;
      dly         <= 0;
      low         <= 0;
      slave       <= 1'b0;
      windingHigh <= 1'b1;
    end
    else
    begin
      gap <= (gap < 1000) ? gap + 1 : gap;
      dly <= (dly > 0) ? dly - 1 : 0;
      low <= (dly == 1) ? LOW_CYC : ((low > 0) ? low - 1 : 0);
      // A stray cycle switched by the primary on its own, with no request.
      if (extraSw)
        dly <= RESP_CYC;
      if (linkPulse_r)
      begin
        gap <= 0;
        if (pair)
          slave <= 1'b1;
        if ((slave || pair) && respond)
          dly <= RESP_CYC;
      end
      windingHigh <= !((dly == 1) || (low > 1));
    end
  end
endmodule
